// ===== pkg/rlc_params.svh
// Purpose: Offsets, bit positions and reset values of the line-code monitor.
// Assumes: Registers stand at their printed byte offsets on a 16-bit port.
// Notes: Definitions only.
`ifndef RLC_PARAMS_SVH
`define RLC_PARAMS_SVH
`define RLC_ADDR_CTRL    8'h90
`define RLC_ADDR_LIVE    8'h94
`define RLC_ADDR_LATCHED 8'h96
`define RLC_ADDR_IRQEN   8'h98
`define RLC_ADDR_VCNT    8'h9C
`define RLC_ADDR_ZCNT    8'h9E
`define RLC_BIT_LOSS     0
`define RLC_BIT_VNZ      1
`define RLC_BIT_VEVT     2
`define RLC_BIT_ZNZ      3
`define RLC_BIT_ZEVT     4
`define RLC_BIT_SIG      5
`define RLC_FLAG_W       6
`define RLC_CTRL_ZSD     0
`define RLC_CTRL_E3      3
`define RLC_FLAGS_RST    6'h00
`define RLC_DATA_ZERO    16'h0000
`define RLC_CNT_W        16
`endif

// ===== pkg/rlc_pkg.sv
// Purpose: Types shared by the line-code monitor and its bench.
// Assumes: Nothing beyond the params header.
// Notes: Structs carry the bus request and the decoder strobes.
package rlc_pkg;
   typedef struct packed
   {
      logic [7:0]  addr;  // Byte offset.
      logic [15:0] wdata; // Write data.
      logic        wr;    // Write strobe.
      logic        rd;    // Read strobe.
   } rlc_bus_req_t;
   typedef struct packed
   {
      logic code_sig; // Substitution signature recognised.
      logic excess_zero_tally;      // Excessive-zero event.
      logic violation_tally;      // Bipolar violation.
      logic bpv_pos;  // Polarity of that violation, 1 = positive.
   } rlc_evt_t;
endpackage

// ===== verification/rlc_dec_model.sv
// Purpose: Line decoder stand-in that drives event strobes and loss level.
// Assumes: The bench raises request bits for one cycle per event.
// Notes: Strobes leave one cycle after the request, as a registered decoder would.
`timescale 1ns/1ps
module rlc_dec_model
(
   input  wire logic         clk_i,  // System clock.
   input  wire logic [3:0]   req_i,  // Signature, excess zero, violation, polarity.
   input  wire logic         loss_i, // Requested loss level.
   output rlc_pkg::rlc_evt_t evt_o,  // Strobes to the monitor.
   output logic              loss_o  // Loss level to the monitor.
);
   always_ff @(posedge clk_i)
   begin
      evt_o  <= rlc_pkg::rlc_evt_t'(req_i);
      loss_o <= loss_i;
   end
endmodule // rlc_dec_model

// ===== verification/rlc_top_tb.sv
// Purpose: Self-checking bench for the line-code monitor.
// Assumes: Counters built 4 bits wide so saturation is reached quickly.
// Notes: Every task starts and ends just after a rising edge.
`timescale 1ns/1ps
`include "rlc_params.svh"
module rlc_top_tb;
   logic                  clk = 1'b0;
   logic                  rst_n = 1'b0;
   rlc_pkg::rlc_bus_req_t bus = '0;
   logic [15:0]           rd_data;
   logic [3:0]            req = 4'h0;
   logic                  loss = 1'b0;
   logic                  hdb3 = 1'b0;
   logic                  perf_monitor_update = 1'b0;
   logic                  port_en = 1'b0;
   logic                  irq;
   rlc_pkg::rlc_evt_t     evt;
   logic                  sig_loss;
   int                    fail_count = 0;
   int                    tests_run = 0;
   int                    cyc = 0;

   rlc_dec_model MDL (.clk_i(clk), .req_i(req), .loss_i(loss), .evt_o(evt), .loss_o(sig_loss));
   rlc_top #(.CNT_W(4)) DUT (.CLK_SYS_I(clk), .RESETN_I(rst_n), .BUS_I(bus), .RD_DATA_O(rd_data),
      .EVT_I(evt), .SIG_LOSS_I(sig_loss), .HDB3_MODE_I(hdb3), .PERF_MON_UPDATE_I(perf_monitor_update),
      .PORT_IRQ_EN_I(port_en), .IRQ_O(irq));

   initial
   begin
      forever #10 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e)
      begin
         fail_count++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 chk(nm, e, rd_data);
      @(posedge clk);
   endtask

   task automatic ev(input logic [3:0] b);
      req <= b;
      @(posedge clk);
      req <= 4'h0;
      repeat (2) @(posedge clk);
   endtask

   task automatic upd();
      perf_monitor_update <= 1'b1;
      @(posedge clk);
      perf_monitor_update <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   task automatic t_reset();
      rd(`RLC_ADDR_IRQEN, 16'h0000, "irqen");
      rd(`RLC_ADDR_VCNT, 16'h0000, "vcnt");
      rd(`RLC_ADDR_ZCNT, 16'h0000, "zcnt");
      wr(`RLC_ADDR_VCNT, 16'h1234);
      rd(`RLC_ADDR_VCNT, 16'h0000, "vcnt ro");
      rd(8'h92, 16'h0000, "unmapped");
   endtask

   task automatic t_flags();
      logic [3:0] kind [3] = '{4'b1000, 4'b0100, 4'b0010};
      int         pos [3] = '{`RLC_BIT_SIG, `RLC_BIT_ZEVT, `RLC_BIT_VEVT};
      for (int i = 0; i < 3; i++)
      begin
         ev(kind[i]);
         rd(`RLC_ADDR_LATCHED, 16'h0001 << pos[i], "flag set");
         wr(`RLC_ADDR_LATCHED, 16'h0001 << pos[i]);
         rd(`RLC_ADDR_LATCHED, 16'h0000, "flag clr");
      end
      req <= 4'b0100;
      @(posedge clk);
      req <= 4'h0;
      wr(`RLC_ADDR_LATCHED, 16'h0010);
      rd(`RLC_ADDR_LATCHED, 16'h0010, "set wins");
      wr(`RLC_ADDR_LATCHED, 16'h003F);
   endtask

   task automatic t_count();
      rd(`RLC_ADDR_VCNT, 16'h0000, "vcnt held");
      upd();
      rd(`RLC_ADDR_VCNT, 16'h0001, "vcnt");
      rd(`RLC_ADDR_ZCNT, 16'h0002, "zcnt");
      rd(`RLC_ADDR_LIVE, 16'h000A, "live nz");
      rd(`RLC_ADDR_LATCHED, 16'h000A, "rise");
      upd();
      rd(`RLC_ADDR_VCNT, 16'h0000, "restart");
      rd(`RLC_ADDR_LIVE, 16'h0000, "live z");
      rd(`RLC_ADDR_LATCHED, 16'h000A, "sticky");
      wr(`RLC_ADDR_LATCHED, 16'h003F);
   endtask

   task automatic t_loss();
      loss <= 1'b1;
      repeat (4) @(posedge clk);
      rd(`RLC_ADDR_LIVE, 16'h0001, "loss on");
      rd(`RLC_ADDR_LATCHED, 16'h0001, "loss chg");
      wr(`RLC_ADDR_LATCHED, 16'h0001);
      loss <= 1'b0;
      repeat (4) @(posedge clk);
      rd(`RLC_ADDR_LIVE, 16'h0000, "loss off");
      rd(`RLC_ADDR_LATCHED, 16'h0001, "loss exit");
      wr(`RLC_ADDR_LATCHED, 16'h0001);
      wr(`RLC_ADDR_CTRL, 16'h0001);
      loss <= 1'b1;
      ev(4'b1000);
      rd(`RLC_ADDR_LIVE, 16'h0000, "loss held");
      rd(`RLC_ADDR_LATCHED, 16'h0000, "ami only");
      loss <= 1'b0;
      wr(`RLC_ADDR_CTRL, 16'h0000);
   endtask

   task automatic t_irq();
      wr(`RLC_ADDR_IRQEN, 16'h0004);
      rd(`RLC_ADDR_IRQEN, 16'h0004, "irqen rw");
      ev(4'b0010);
      chk("irq port off", 16'h0000, {15'h0000, irq});
      port_en <= 1'b1;
      repeat (2) @(posedge clk);
      chk("irq on", 16'h0001, {15'h0000, irq});
      wr(`RLC_ADDR_IRQEN, 16'h0000);
      @(posedge clk);
      chk("irq masked", 16'h0000, {15'h0000, irq});
      wr(`RLC_ADDR_IRQEN, 16'h0004);
      wr(`RLC_ADDR_LATCHED, 16'h0004);
      @(posedge clk);
      chk("irq cleared", 16'h0000, {15'h0000, irq});
      upd();
      upd();
      wr(`RLC_ADDR_LATCHED, 16'h003F);
   endtask

   task automatic t_e3();
      wr(`RLC_ADDR_CTRL, 16'h0008);
      rd(`RLC_ADDR_CTRL, 16'h0008, "ctrl rw");
      hdb3 <= 1'b1;
      ev(4'b0011);
      ev(4'b0010);
      ev(4'b0011);
      ev(4'b0011);
      upd();
      rd(`RLC_ADDR_VCNT, 16'h0001, "e3 lcv");
      hdb3 <= 1'b0;
      ev(4'b0010);
      ev(4'b0011);
      upd();
      rd(`RLC_ADDR_VCNT, 16'h0002, "b3zs ign");
      wr(`RLC_ADDR_CTRL, 16'h0000);
   endtask

   task automatic t_sat();
      repeat (20) ev(4'b0010);
      upd();
      rd(`RLC_ADDR_VCNT, 16'h000F, "saturate");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fail_count++;
         results();
      end
   end

   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_flags();
      t_count();
      t_loss();
      t_irq();
      t_e3();
      t_sat();
      results();
   end
endmodule // rlc_top_tb

// ===== verilog/rlc_top.sv
// Purpose: Receive line-code status, latched flags, interrupt and counters.
// Assumes: All inputs come from logic on CLK_SYS_I, so none is synchronised.
// Notes: Read data stands in the cycle after the read strobe and only then.
//
// Contract
// - Live bit 3 is one while the excess-zero count is nonzero.
// - Live bit 1 is one while the violation count is nonzero.
// - Live bit 0 is one while the line is in signal loss.
// - Latched bit 5 sets on each recognised substitution signature.
// - Latched bit 4 sets on each excessive-zero event.
// - Latched bit 3 sets only when live bit 3 rises.
// - Latched bit 2 sets on a violation, or E3 coding violation when chosen.
// - Latched bit 1 sets only when live bit 1 rises.
// - Latched bit 0 sets on every change of live bit 0.
// - With suppression decoding off, signal loss is held cleared.
// - Interrupt needs enable bit, its flag and the port enable all set.
// - After reset enables and both counters read zero.
// - A 16-bit register shows the violation count.
// - A 16-bit register shows the excess-zero count.
// - Count registers change only on the update pulse.
// - E3 select counts same-polarity violation pairs, ignored in B3ZS mode.
// - Suppression disable skips signature decoding, AMI only.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "rlc_params.svh"

module rlc_top
#(
   parameter int CNT_W = `RLC_CNT_W
)
(
   input  wire logic                  CLK_SYS_I,        // System clock, 50 MHz.
   input  wire logic                  RESETN_I,         // Asynchronous reset, low.
   input  wire rlc_pkg::rlc_bus_req_t BUS_I,            // Register request.
   output logic [15:0]                RD_DATA_O,        // Read data, one cycle later.
   input  wire rlc_pkg::rlc_evt_t     EVT_I,            // Decoder event strobes.
   input  wire logic                  SIG_LOSS_I,       // Raw signal-loss level.
   input  wire logic                  HDB3_MODE_I,      // 1 = HDB3 (E3), 0 = B3ZS.
   input  wire logic                  PERF_MON_UPDATE_I, // Count update pulse.
   input  wire logic                  PORT_IRQ_EN_I,    // Port status irq enable.
   output logic                       IRQ_O             // Level interrupt.
);

   // A count wider than the 16-bit read word could not be shown whole.
   if (CNT_W < 1 || CNT_W > `RLC_CNT_W)
   begin : g_cnt_w_check
      $error("CNT_W must lie between 1 and 16");
   end

   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!RESETN_I);

   localparam logic [CNT_W-1:0] CNT_MAX = '1;

   logic                  zsd_disable;
   logic                  e3_select;
   logic [`RLC_FLAG_W-1:0] latched;
   logic [`RLC_FLAG_W-1:0] irq_en;
   logic                  signal_loss;
   logic [CNT_W-1:0]      v_acc;
   logic [CNT_W-1:0]      z_acc;
   logic [CNT_W-1:0]      v_cnt;
   logic [CNT_W-1:0]      z_cnt;
   logic                  prev_bpv_valid;
   logic                  prev_bpv_pos;

   logic                  wr_ctrl;
   logic                  wr_latched;
   logic                  wr_irqen;
   logic                  next_loss;
   logic                  line_coding_violation;
   logic                  viol_evt;
   logic                  sig_evt;
   logic [CNT_W-1:0]      next_v_cnt;
   logic [CNT_W-1:0]      next_z_cnt;
   logic                  v_nz;
   logic                  z_nz;
   logic [`RLC_FLAG_W-1:0] set_flags;
   logic [`RLC_FLAG_W-1:0] clr_flags;
   logic [15:0]           live_word;
   logic [15:0]           next_rd_data;

   assign wr_ctrl    = BUS_I.wr && (BUS_I.addr == `RLC_ADDR_CTRL);
   assign wr_latched = BUS_I.wr && (BUS_I.addr == `RLC_ADDR_LATCHED);
   assign wr_irqen   = BUS_I.wr && (BUS_I.addr == `RLC_ADDR_IRQEN);

   // Decoder control bits.
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         zsd_disable <= 1'b0;
         e3_select   <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         zsd_disable <= BUS_I.wdata[`RLC_CTRL_ZSD];
         e3_select   <= BUS_I.wdata[`RLC_CTRL_E3];
      end
   end

   // Interrupt enables.
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         irq_en <= `RLC_FLAGS_RST;
      end
      else if (wr_irqen)
      begin
         irq_en <= BUS_I.wdata[`RLC_FLAG_W-1:0];
      end
   end

   // Loss detection is forced off while only AMI decoding runs.
   assign next_loss = zsd_disable ? 1'b0 : SIG_LOSS_I;

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         signal_loss <= 1'b0;
      end
      else
      begin
         signal_loss <= next_loss;
      end
   end

   // Polarity of the last violation, for same-polarity pairs.
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         prev_bpv_valid <= 1'b0;
         prev_bpv_pos   <= 1'b0;
      end
      else if (EVT_I.violation_tally)
      begin
         prev_bpv_valid <= 1'b1;
         prev_bpv_pos   <= EVT_I.bpv_pos;
      end
   end

   assign line_coding_violation = EVT_I.violation_tally && prev_bpv_valid && (EVT_I.bpv_pos == prev_bpv_pos);

   // The E3 choice only counts in HDB3 mode.
   assign viol_evt = (e3_select && HDB3_MODE_I) ? line_coding_violation : EVT_I.violation_tally;

   // No signature decoding takes place while suppression is disabled.
   assign sig_evt = EVT_I.code_sig && !zsd_disable;

   // Accumulators restart on update; an event in that cycle counts as one.
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         v_acc <= '0;
      end
      else if (PERF_MON_UPDATE_I)
      begin
         v_acc <= CNT_W'(viol_evt);
      end
      else if (viol_evt && v_acc != CNT_MAX)
      begin
         v_acc <= v_acc + CNT_W'(1);
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         z_acc <= '0;
      end
      else if (PERF_MON_UPDATE_I)
      begin
         z_acc <= CNT_W'(EVT_I.excess_zero_tally);
      end
      else if (EVT_I.excess_zero_tally && z_acc != CNT_MAX)
      begin
         z_acc <= z_acc + CNT_W'(1);
      end
   end

   assign next_v_cnt = PERF_MON_UPDATE_I ? v_acc : v_cnt;
   assign next_z_cnt = PERF_MON_UPDATE_I ? z_acc : z_cnt;

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         v_cnt <= '0;
         z_cnt <= '0;
      end
      else
      begin
         v_cnt <= next_v_cnt;
         z_cnt <= next_z_cnt;
      end
   end

   assign v_nz = (v_cnt != '0);
   assign z_nz = (z_cnt != '0);

   // Flag set terms, each on the cycle its cause appears.
   always_comb
   begin
      set_flags                = `RLC_FLAGS_RST;
      set_flags[`RLC_BIT_SIG]  = sig_evt;
      set_flags[`RLC_BIT_ZEVT] = EVT_I.excess_zero_tally;
      set_flags[`RLC_BIT_ZNZ]  = (next_z_cnt != '0) && !z_nz;
      set_flags[`RLC_BIT_VEVT] = viol_evt;
      set_flags[`RLC_BIT_VNZ]  = (next_v_cnt != '0) && !v_nz;
      set_flags[`RLC_BIT_LOSS] = (next_loss != signal_loss);
   end

   assign clr_flags = wr_latched ? BUS_I.wdata[`RLC_FLAG_W-1:0] : `RLC_FLAGS_RST;

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         latched <= `RLC_FLAGS_RST;
      end
      else
      begin
         latched <= (latched & ~clr_flags) | set_flags;
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         IRQ_O <= 1'b0;
      end
      else
      begin
         IRQ_O <= PORT_IRQ_EN_I && ((latched & irq_en) != `RLC_FLAGS_RST);
      end
   end

   always_comb
   begin
      live_word                = `RLC_DATA_ZERO;
      live_word[`RLC_BIT_ZNZ]  = z_nz;
      live_word[`RLC_BIT_VNZ]  = v_nz;
      live_word[`RLC_BIT_LOSS] = signal_loss;
   end

   // Unmapped offsets and idle cycles read as zero.
   always_comb
   begin
      next_rd_data = `RLC_DATA_ZERO;
      if (BUS_I.rd)
      begin
         unique case (BUS_I.addr)
            `RLC_ADDR_CTRL:
            begin
               next_rd_data[`RLC_CTRL_ZSD] = zsd_disable;
               next_rd_data[`RLC_CTRL_E3]  = e3_select;
            end
            `RLC_ADDR_LIVE:    next_rd_data = live_word;
            `RLC_ADDR_LATCHED: next_rd_data[`RLC_FLAG_W-1:0] = latched;
            `RLC_ADDR_IRQEN:   next_rd_data[`RLC_FLAG_W-1:0] = irq_en;
            `RLC_ADDR_VCNT:    next_rd_data = 16'(v_cnt);
            `RLC_ADDR_ZCNT:    next_rd_data = 16'(z_cnt);
            default:           next_rd_data = `RLC_DATA_ZERO;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         RD_DATA_O <= `RLC_DATA_ZERO;
      end
      else
      begin
         RD_DATA_O <= next_rd_data;
      end
   end

   zcnt_live_a: assert property (
      $rose(z_nz) |-> $past(PERF_MON_UPDATE_I) && $past(z_acc) != '0)
      else $error("Excess-zero nonzero bit rose without an update");

   vcnt_live_a: assert property (
      BUS_I.rd && BUS_I.addr == `RLC_ADDR_LIVE
         |=> RD_DATA_O[`RLC_BIT_VNZ] == ($past(v_cnt) != '0))
      else $error("Violation nonzero bit wrong on read");

   loss_live_a: assert property (
      !zsd_disable && $past(!zsd_disable) |-> signal_loss == $past(SIG_LOSS_I))
      else $error("Live loss bit does not follow detector");

   sig_flag_a: assert property (
      EVT_I.code_sig && !zsd_disable |=> latched[`RLC_BIT_SIG])
      else $error("Signature flag not set");

   zevt_flag_a: assert property (
      EVT_I.excess_zero_tally |=> latched[`RLC_BIT_ZEVT])
      else $error("Excess-zero flag not set");

   zrise_flag_a: assert property (
      $rose(latched[`RLC_BIT_ZNZ]) |-> $rose(z_nz))
      else $error("Excess-zero count flag set without a rise");

   vevt_flag_a: assert property (
      EVT_I.violation_tally && !e3_select |=> latched[`RLC_BIT_VEVT])
      else $error("Violation flag not set");

   vrise_flag_a: assert property (
      $rose(latched[`RLC_BIT_VNZ]) |-> $rose(v_nz))
      else $error("Violation count flag set without a rise");

   loss_flag_a: assert property (
      signal_loss != $past(signal_loss) |-> latched[`RLC_BIT_LOSS])
      else $error("Loss change flag not set");

   loss_held_a: assert property (
      zsd_disable [*2] |-> !signal_loss)
      else $error("Loss seen with suppression decoding off");

   irq_gate_a: assert property (
      IRQ_O |-> $past(PORT_IRQ_EN_I) && $past((latched & irq_en) != '0))
      else $error("Interrupt raised without an enabled flag");

   cnt_hold_a: assert property (
      !$past(PERF_MON_UPDATE_I) |-> $stable(v_cnt) && $stable(z_cnt))
      else $error("Count changed without an update");

   e3_pair_a: assert property (
      e3_select && HDB3_MODE_I && EVT_I.violation_tally && !line_coding_violation |=> v_acc == $past(v_acc)
         || $past(PERF_MON_UPDATE_I))
      else $error("Single violation counted in E3 mode");

   flag_hold_a: assert property (
      latched[`RLC_BIT_ZEVT] && !(wr_latched && BUS_I.wdata[`RLC_BIT_ZEVT])
         |=> latched[`RLC_BIT_ZEVT])
      else $error("Flag dropped without a clear");

   acc_sat_a: assert property (
      v_acc == CNT_MAX && !PERF_MON_UPDATE_I |=> v_acc == CNT_MAX)
      else $error("Violation accumulator wrapped");

   // Checks on reset values, the read path, AMI signature drop, loads, the interrupt level and saturation.
   rst_vals_a: assert property (
      $rose(RESETN_I) |-> irq_en == '0 && v_cnt == '0 && z_cnt == '0)
      else $error("Enables or counts not zero after reset");

   vcnt_read_a: assert property (
      BUS_I.rd && BUS_I.addr == `RLC_ADDR_VCNT |=> RD_DATA_O == 16'($past(v_cnt)))
      else $error("Violation count read wrong");

   zcnt_read_a: assert property (
      BUS_I.rd && BUS_I.addr == `RLC_ADDR_ZCNT |=> RD_DATA_O == 16'($past(z_cnt)))
      else $error("Excess-zero count read wrong");

   sig_drop_a: assert property (
      EVT_I.code_sig && zsd_disable && !latched[`RLC_BIT_SIG] |=> !latched[`RLC_BIT_SIG])
      else $error("Signature flagged while only AMI decoding runs");

   cnt_load_a: assert property (
      PERF_MON_UPDATE_I |=> v_cnt == $past(v_acc) && z_cnt == $past(z_acc))
      else $error("Counts did not load from the accumulators");

   irq_set_a: assert property (
      PORT_IRQ_EN_I && (latched & irq_en) != '0 |=> IRQ_O)
      else $error("Interrupt missing for an enabled flag");

   zacc_sat_a: assert property (
      z_acc == CNT_MAX && !PERF_MON_UPDATE_I |=> z_acc == CNT_MAX)
      else $error("Excess-zero accumulator wrapped");

endmodule // rlc_top
